/* smx_pkg.sv */
package smx_pkg;
    localparam int unsigned SMX_ADDR_W = 12;
    localparam int unsigned SMX_DATA_W = 32;
    localparam int unsigned SMX_SLOTS = 8;
    localparam int unsigned SMX_SEL_W = 2;
    localparam int unsigned SMX_FIELD_STRIDE = 4;
    localparam int unsigned SMX_FIELD_LSB0 = 0;
    localparam int unsigned SMX_SLOT_W = 3;
    localparam logic [11:0] SMX_OFF_INPUT_SELECT = 12'h040;
    localparam logic [11:0] SMX_OFF_PROC_TRIGGER = 12'h028;
    localparam logic [11:0] SMX_OFF_ENABLE = 12'h000;
    localparam logic [11:0] SMX_OFF_STATUS = 12'h004;
    localparam logic [31:0] SMX_RST_INPUT_SELECT = 32'h0000_0000;
    localparam logic [31:0] SMX_SEL_MASK = 32'h3333_3333;
    localparam int unsigned SMX_TRIG_BIT = 0;
    localparam int unsigned SMX_ENABLE_BIT = 0;
    localparam int unsigned SMX_SETTLE_NS = 16;
    localparam int unsigned SMX_CLK_MHZ = 125;
    localparam int unsigned SMX_SETTLE_CYC =
        (SMX_SETTLE_NS * SMX_CLK_MHZ + 999) / 1000;
    localparam int unsigned SMX_CONV_CYC = 16;

    typedef enum logic [2:0] {
        SMX_IDLE = 3'h1,
        SMX_SETTLE = 3'h2,
        SMX_CONVERT = 3'h4
    } smx_state_t;

    function automatic logic [1:0] smx_field(input logic [31:0] r,
                                             input logic [2:0] slot);
        logic [4:0] lsb;
        lsb = {slot, 2'h0};
        smx_field = r[lsb +: 2];
    endfunction : smx_field
endpackage : smx_pkg

/* smx_onehot.sv */
`timescale 1ns/1ps
`default_nettype none
// Turns a pin number into a one-hot select for the analog switch.
module smx_onehot
    import smx_pkg::*;
#(
    parameter int unsigned SEL_W = 2
) (
    input wire logic [SEL_W-1:0] sel,
    output logic [(1<<SEL_W)-1:0] onehot
);
    always_comb begin
        onehot = '0;
        onehot[sel] = 1'b1;
    end
endmodule : smx_onehot
`default_nettype wire

/* smx_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Down counter giving a one-cycle done pulse after a loaded count.
module smx_timer
    import smx_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] count,
    output logic done
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic run_q, run_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done = 1'b0;
        if (load) begin
            cnt_d = count;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= CNT_W'(1)) begin
                run_d = 1'b0;
                done = 1'b1;
            end else begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule : smx_timer
`default_nettype wire

/* smx_seq0_mux.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - One register holds the input choice for every slot of sequencer 0.
// - The register is 32 bits with eight 2-bit fields at every fourth bit.
// - Field bits 29:28 pick the input for the eighth sample.
// - A field value is the number of the analog pin sampled.
// - Reserved bits have no defined meaning and software must keep them.
// - All bits reset to zero; fields read-write, reserved bits read-only.
// - Field bits 1:0 serve the first sample, higher fields later ones.
// - Writing one to the trigger bit starts sequencer 0 when enabled.
module smx_seq0_mux
    import smx_pkg::*;
#(
    parameter int unsigned SLOTS = SMX_SLOTS,
    parameter int unsigned CONV_CYC = SMX_CONV_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [SMX_ADDR_W-1:0] reg_addr,
    input wire logic [SMX_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SMX_DATA_W-1:0] reg_rdata,
    output logic [SMX_SEL_W-1:0] mux_sel,
    output logic [(1<<SMX_SEL_W)-1:0] mux_onehot,
    output logic [SMX_SLOT_W-1:0] cur_slot,
    output logic conv_start,
    output logic seq_busy
);
    logic [31:0] sel_q, sel_d;
    logic en_q, en_d;
    logic [31:0] rdata_q, rdata_d;
    smx_state_t st_q, st_d;
    logic [SMX_SLOT_W-1:0] slot_q, slot_d;
    logic [SMX_SEL_W-1:0] msel_q, msel_d;
    logic [(1<<SMX_SEL_W)-1:0] oh_q, oh_comb;
    logic start_q, start_d;
    logic busy_q;
    logic trig;
    logic tload;
    logic [7:0] tcount;
    logic tdone;

    assign trig = reg_wr && reg_addr == SMX_OFF_PROC_TRIGGER
        && reg_wdata[SMX_TRIG_BIT] && en_q;

    // Register file and read port.
    always_comb begin
        sel_d = sel_q;
        en_d = en_q;
        rdata_d = '0;
        if (reg_wr) begin
            if (reg_addr == SMX_OFF_INPUT_SELECT) begin
                // Reserved positions are not stored, so they stay zero.
                sel_d = reg_wdata & SMX_SEL_MASK;
            end else if (reg_addr == SMX_OFF_ENABLE) begin
                en_d = reg_wdata[SMX_ENABLE_BIT];
            end
        end
        if (reg_rd) begin
            if (reg_addr == SMX_OFF_INPUT_SELECT) begin
                rdata_d = sel_q;
            end else if (reg_addr == SMX_OFF_ENABLE) begin
                rdata_d = {31'h0, en_q};
            end else if (reg_addr == SMX_OFF_STATUS) begin
                rdata_d = {27'h0, slot_q, 1'b0, st_q != SMX_IDLE};
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= SMX_RST_INPUT_SELECT;
            en_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            sel_q <= sel_d;
            en_q <= en_d;
            rdata_q <= rdata_d;
        end
    end

    // Slot stepper: settle one cycle with the select applied, then convert.
    always_comb begin
        st_d = st_q;
        slot_d = slot_q;
        msel_d = msel_q;
        start_d = 1'b0;
        tload = 1'b0;
        tcount = 8'(CONV_CYC);
        case (st_q)
            SMX_IDLE: begin
                if (trig) begin
                    slot_d = '0;
                    msel_d = smx_field(sel_q, 3'h0);
                    st_d = SMX_SETTLE;
                end
            end
            SMX_SETTLE: begin
                start_d = 1'b1;
                tload = 1'b1;
                st_d = SMX_CONVERT;
            end
            SMX_CONVERT: begin
                if (tdone) begin
                    if (slot_q == SMX_SLOT_W'(SLOTS - 1)) begin
                        st_d = SMX_IDLE;
                    end else begin
                        slot_d = slot_q + 3'h1;
                        // Next field, up to bits 29:28 for slot seven.
                        msel_d = smx_field(sel_q, slot_q + 3'h1);
                        st_d = SMX_SETTLE;
                    end
                end
            end
            default: st_d = SMX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= SMX_IDLE;
            slot_q <= '0;
            msel_q <= '0;
            start_q <= 1'b0;
            oh_q <= '0;
            busy_q <= 1'b0;
        end else begin
            // Registered from the next state so the port comes off a flop.
            busy_q <= st_d != SMX_IDLE;
            st_q <= st_d;
            slot_q <= slot_d;
            msel_q <= msel_d;
            start_q <= start_d;
            oh_q <= oh_comb;
        end
    end

    smx_onehot #(.SEL_W(SMX_SEL_W)) u_onehot (
        .sel(msel_d),
        .onehot(oh_comb)
    );

    smx_timer #(.CNT_W(8)) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );

    assign reg_rdata = rdata_q;
    assign mux_sel = msel_q;
    assign mux_onehot = oh_q;
    assign cur_slot = slot_q;
    assign conv_start = start_q;
    assign seq_busy = busy_q;
endmodule : smx_seq0_mux
`default_nettype wire

/* smx_seq0_mux_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module smx_seq0_mux_monitor
    import smx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [SMX_ADDR_W-1:0] reg_addr,
    input wire logic [SMX_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [SMX_DATA_W-1:0] reg_rdata,
    input wire logic [SMX_SEL_W-1:0] mux_sel,
    input wire logic [(1<<SMX_SEL_W)-1:0] mux_onehot,
    input wire logic [SMX_SLOT_W-1:0] cur_slot,
    input wire logic conv_start,
    input wire logic seq_busy
);
    logic sel_rd_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_rd_q <= 1'b0;
        end else begin
            sel_rd_q <= reg_rd && reg_addr == SMX_OFF_INPUT_SELECT;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rd");
    reserved_zero_a:
    assert property (sel_rd_q |-> (reg_rdata & ~SMX_SEL_MASK) == 32'h0)
        else $error("reserved");
    onehot_pin_a:
    assert property (seq_busy |-> mux_onehot == 4'h1 << mux_sel)
        else $error("onehot");
    start_busy_a:
    assert property (conv_start |-> seq_busy) else $error("start idle");
    first_slot_a:
    assert property ($rose(seq_busy) |-> cur_slot == 3'h0 ##1 conv_start)
        else $error("first slot");
    slot_step_a:
    assert property (seq_busy && $past(seq_busy) && $changed(cur_slot)
        |-> cur_slot == $past(cur_slot) + 3'h1) else $error("step");
    sel_hold_a:
    assert property (seq_busy && $past(seq_busy) && $stable(cur_slot)
        |-> $stable(mux_sel)) else $error("sel moved");
    conv_gap_a:
    assert property (conv_start |=> !conv_start [*3]) else $error("gap");
    last_slot_a:
    assert property ($fell(seq_busy) |-> $past(cur_slot) == 3'h7)
        else $error("last slot");
endmodule : smx_seq0_mux_monitor
bind smx_seq0_mux smx_seq0_mux_monitor i_mon (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mux_sel(mux_sel), .mux_onehot(mux_onehot), .cur_slot(cur_slot),
    .conv_start(conv_start), .seq_busy(seq_busy));
`default_nettype wire

/* smx_seq0_mux_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module smx_seq0_mux_tb;
    import smx_pkg::*;
    localparam logic [31:0] PAT = 32'h2103_3210;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [1:0] mux_sel;
    logic [3:0] mux_onehot;
    logic [2:0] cur_slot;
    logic conv_start;
    logic seq_busy;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    always #4 clk_sys = ~clk_sys;
    smx_seq0_mux #(.CONV_CYC(4)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mux_sel(mux_sel),
        .mux_onehot(mux_onehot), .cur_slot(cur_slot),
        .conv_start(conv_start), .seq_busy(seq_busy));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
        @(posedge clk_sys);
    endtask : rd
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #20000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd(SMX_OFF_INPUT_SELECT, 32'h0);
        wr(SMX_OFF_INPUT_SELECT, 32'hffff_ffff);
        rd(SMX_OFF_INPUT_SELECT, SMX_SEL_MASK);
        rd(12'h3fc, 32'h0);
        wr(SMX_OFF_PROC_TRIGGER, 32'h1);
        repeat (4) @(negedge clk_sys);
        chk({31'h0, seq_busy}, 32'h0);
        @(posedge clk_sys);
        wr(SMX_OFF_INPUT_SELECT, PAT);
        rd(SMX_OFF_INPUT_SELECT, PAT);
        wr(SMX_OFF_ENABLE, 32'h1);
        wr(SMX_OFF_PROC_TRIGGER, 32'h1);
        for (int k = 0; k < 8; k++) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (conv_start !== 1'b1 && n < 100);
            chk({31'h0, conv_start}, 32'h1);
            chk({29'h0, cur_slot}, k);
            chk({30'h0, mux_sel}, {30'h0, PAT[4*k +: 2]});
            chk({28'h0, mux_onehot}, 32'h1 << PAT[4*k +: 2]);
        end
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (seq_busy !== 1'b0 && n < 100);
        chk({31'h0, seq_busy}, 32'h0);
        summarize();
    end
endmodule : smx_seq0_mux_tb
`default_nettype wire
